/* design/fdp_pkg.sv */
package fdp_pkg;
    // ----------------------------------------
    // Bus widths and burst counter
    // ----------------------------------------
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int BEAT_W = 8;
    localparam int MEM_AW = 8;
    localparam int BLK_AW = 2;
    localparam int PROT_AW = 3;

    // ----------------------------------------
    // Read configuration register layout
    // ----------------------------------------
    localparam logic [15:0] RCR_RESET = 16'h8000;
    localparam int RCR_ASYNC_BIT = 15;
    localparam int RCR_WAIT_POL_BIT = 10;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_IDENT = 8'h90;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_PROT_PROG = 8'hc0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
    localparam logic [7:0] CMD_UNLOCK = 8'hd0;
    localparam logic [7:0] CMD_SET_RCR = 8'h03;

    // ----------------------------------------
    // Status bits and identifier offsets
    // ----------------------------------------
    localparam int STATUS_READY_BIT = 7;
    localparam int STATUS_SEQ_ERR_BIT = 4;
    localparam int STATUS_LOCK_ERR_BIT = 1;
    localparam logic [7:0] IDENT_MAKER = 8'h00;
    localparam logic [7:0] IDENT_DEVICE = 8'h01;
    localparam logic [7:0] IDENT_LOCK = 8'h02;
    localparam logic [7:0] IDENT_RCR = 8'h05;
    localparam logic [7:0] IDENT_PROT_BASE = 8'h80;
    // Arbitrary identity values
    localparam logic [15:0] MAKER_CODE = 16'h00a5;
    localparam logic [15:0] DEVICE_CODE = 16'h5a3c;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {FDP_CMD_IDLE, FDP_CMD_PROGRAM, FDP_CMD_LOCK, FDP_CMD_PROT} fdp_cmd_t;
    typedef enum logic [1:0] {FDP_RD_ARRAY, FDP_RD_STATUS, FDP_RD_IDENT} fdp_rd_t;
endpackage

/* design/fdp_gray_sync.sv */
module fdp_gray_sync #(
    parameter int W = 8
) (
    input  wire logic         srcClk,
    input  wire logic         srcRstN,
    input  wire logic [W-1:0] srcBin,
    input  wire logic         dstClk,
    input  wire logic         dstRstN,
    output logic      [W-1:0] dstBin
);
    logic [W-1:0] srcGray;
    logic [W-1:0] dstMeta;
    logic [W-1:0] dstGray;
    logic [W-1:0] next_dstBin;

    // Gray code in the source domain
    always_ff @(posedge srcClk or negedge srcRstN)
        if (!srcRstN)
            srcGray <= '0;
        else
            srcGray <= srcBin ^ (srcBin >> 1);

    // Two stages into the destination domain
    always_ff @(posedge dstClk or negedge dstRstN)
        if (!dstRstN)
        begin
            dstMeta <= '0;
            dstGray <= '0;
            dstBin  <= '0;
        end
        else
        begin
            dstMeta <= srcGray;
            dstGray <= dstMeta;
            dstBin  <= next_dstBin;
        end

    // Gray back to binary
    always_comb
    begin
        next_dstBin[W-1] = dstGray[W-1];
        for (int i = W - 2; i >= 0; i--)
            next_dstBin[i] = next_dstBin[i+1] ^ dstGray[i];
    end
endmodule

/* design/fdp_bus_port.sv */
// Operation
// - Address width follows density: top bit 20, 21 or 22.
// - Data bus takes writes and returns array, status, ident, configuration.
// - Data bus floats when deselected or outputs disabled.
// - Low select activates the die logic.
// - Deselect means standby and floating data and wait.
// - Reset pin low resets state and blocks writes.
// - After reset the die reads the array asynchronously.
// - Low output enable drives read data, high floats it.
// - Low write enable feeds decoder, array, protection, lock, configuration.
// - Address and data captured at write enable rising edge.
// - Sync reads latch address at address valid rise or clock edge; the code takes it at address valid rise only, not at a link clock edge.
// - Link clock advances the burst counter while selected with address valid high, in any mode.
// - Wait driven while selected; level set by polarity bit.
// - Sync array reads: wait marks invalid data, host samples when clear.
// - Wait held asserted for non-array sync, async and write modes.
module fdp_bus_port #(
    parameter int ADDR_W = fdp_pkg::ADDR_W,
    parameter int MEM_AW = fdp_pkg::MEM_AW,
    parameter int BLK_AW = fdp_pkg::BLK_AW,
    parameter int PROT_AW = fdp_pkg::PROT_AW,
    parameter int BEAT_W = fdp_pkg::BEAT_W,
    parameter bit CLK_FALL = 1'b0
) (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              busClk,
    input  wire logic [ADDR_W-1:0] addrIn,
    input  wire logic [15:0]       dataIn,
    output logic      [15:0]       dataOut,
    output logic                   dataOe,
    input  wire logic              selectN,
    input  wire logic              outEnableN,
    input  wire logic              writeEnableN,
    input  wire logic              address_valid_n,
    input  wire logic              resetPinN,
    output logic                   waitOut,
    output logic                   waitOe,
    output logic                   standby
);
    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic [1:0]        rstSync;
    logic              coreRstN;
    logic [4:0]        ctlMeta;
    logic [4:0]        ctlSync;
    logic [4:0]        ctlPrev;
    logic [ADDR_W-1:0] addrMeta;
    logic [ADDR_W-1:0] addrSync;
    logic [15:0]       dataMeta;
    logic [15:0]       dataSync;

    assign coreRstN = rstSync[1];

    // Core reset release
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'b1};

    // Pins pass two stages
    always_ff @(posedge core_clk or negedge coreRstN)
        if (!coreRstN)
        begin
            ctlMeta  <= 5'h1f;
            ctlSync  <= 5'h1f;
            ctlPrev  <= 5'h1f;
            addrMeta <= '0;
            addrSync <= '0;
            dataMeta <= 16'h0;
            dataSync <= 16'h0;
        end
        else
        begin
            ctlMeta  <= {selectN, outEnableN, writeEnableN, address_valid_n, resetPinN};
            ctlSync  <= ctlMeta;
            ctlPrev  <= ctlSync;
            addrMeta <= addrIn;
            addrSync <= addrMeta;
            dataMeta <= dataIn;
            dataSync <= dataMeta;
        end

    // Pin decode
    logic selAct;
    logic oeAct;
    logic weAct;
    logic advAct;
    logic pinRst;
    logic weRise;
    logic advRise;
    logic writeStrobe;

    assign selAct = !ctlSync[4];
    assign oeAct = !ctlSync[3];
    assign weAct = !ctlSync[2];
    assign advAct = !ctlSync[1];
    assign pinRst = !ctlSync[0];
    assign weRise = !ctlPrev[2] && ctlSync[2];
    assign advRise = !ctlPrev[1] && ctlSync[1];
    assign writeStrobe = weRise && !ctlPrev[4] && !pinRst;

    // ----------------------------------------
    // Write capture and command decoder
    // ----------------------------------------
    fdp_pkg::fdp_cmd_t command_decoder;
    fdp_pkg::fdp_cmd_t next_command_decoder;
    fdp_pkg::fdp_rd_t  rdMode;
    fdp_pkg::fdp_rd_t  next_rdMode;
    logic [15:0]       read_configuration_register;
    logic [15:0]       next_read_configuration_register;
    logic [6:0]        statusReg;
    logic [6:0]        next_statusReg;
    logic [(1<<BLK_AW)-1:0] lockBits;
    logic [(1<<BLK_AW)-1:0] next_lockBits;
    logic              writePending;
    logic [ADDR_W-1:0] latchedAddr;
    logic [15:0]       latchedData;
    logic [15:0]       memArray [1<<MEM_AW];
    logic [15:0]       protection_and_lock_registers [1<<PROT_AW];

    logic [7:0]        cmdByte;
    logic [MEM_AW-1:0] wrIdx;
    logic [BLK_AW-1:0] wrBlk;
    logic              wrLocked;
    logic              doProgram;
    logic              doProt;

    assign cmdByte = latchedData[7:0];
    assign wrIdx = latchedAddr[MEM_AW-1:0];
    assign wrBlk = latchedAddr[MEM_AW-1 -: BLK_AW];
    assign wrLocked = lockBits[wrBlk];
    assign doProgram = writePending && command_decoder == fdp_pkg::FDP_CMD_PROGRAM && !wrLocked;
    assign doProt = writePending && command_decoder == fdp_pkg::FDP_CMD_PROT;

    always_ff @(posedge core_clk or negedge coreRstN)
        if (!coreRstN)
        begin
            writePending <= 1'b0;
            latchedAddr  <= '0;
            latchedData  <= 16'h0;
        end
        else
        begin
            writePending <= writeStrobe;
            if (writeStrobe)
            begin
                latchedAddr <= addrSync;
                latchedData <= dataSync;
            end
        end

    always_comb
    begin
        next_command_decoder = fdp_pkg::FDP_CMD_IDLE;
        next_rdMode = rdMode;
        next_read_configuration_register = read_configuration_register;
        next_statusReg = statusReg;
        next_lockBits = lockBits;
        if (!writePending)
            next_command_decoder = command_decoder;
        else
            case (command_decoder)
                fdp_pkg::FDP_CMD_IDLE:
                    case (cmdByte)
                        fdp_pkg::CMD_READ_ARRAY: next_rdMode = fdp_pkg::FDP_RD_ARRAY;
                        fdp_pkg::CMD_READ_STATUS: next_rdMode = fdp_pkg::FDP_RD_STATUS;
                        fdp_pkg::CMD_READ_IDENT: next_rdMode = fdp_pkg::FDP_RD_IDENT;
                        fdp_pkg::CMD_CLEAR_STATUS: next_statusReg = 7'h0;
                        fdp_pkg::CMD_PROGRAM, fdp_pkg::CMD_PROG_ALT:
                        begin
                            next_command_decoder = fdp_pkg::FDP_CMD_PROGRAM;
                            next_rdMode = fdp_pkg::FDP_RD_STATUS;
                        end
                        fdp_pkg::CMD_PROT_PROG:
                        begin
                            next_command_decoder = fdp_pkg::FDP_CMD_PROT;
                            next_rdMode = fdp_pkg::FDP_RD_STATUS;
                        end
                        fdp_pkg::CMD_LOCK_SETUP: next_command_decoder = fdp_pkg::FDP_CMD_LOCK;
                        default: ;
                    endcase
                fdp_pkg::FDP_CMD_PROGRAM:
                    if (wrLocked)
                        next_statusReg[fdp_pkg::STATUS_LOCK_ERR_BIT] = 1'b1;
                fdp_pkg::FDP_CMD_LOCK:
                    case (cmdByte)
                        fdp_pkg::CMD_LOCK_BLOCK: next_lockBits[wrBlk] = 1'b1;
                        fdp_pkg::CMD_UNLOCK: next_lockBits[wrBlk] = 1'b0;
                        fdp_pkg::CMD_SET_RCR: next_read_configuration_register = latchedAddr[15:0];
                        default: next_statusReg[fdp_pkg::STATUS_SEQ_ERR_BIT] = 1'b1;
                    endcase
                default: ;
            endcase
    end

    // reset pin returns to async array reads
    always_ff @(posedge core_clk or negedge coreRstN)
        if (!coreRstN)
        begin
            command_decoder <= fdp_pkg::FDP_CMD_IDLE;
            rdMode <= fdp_pkg::FDP_RD_ARRAY;
            read_configuration_register <= fdp_pkg::RCR_RESET;
            statusReg <= 7'h0;
            lockBits <= '0;
        end
        else if (pinRst)
        begin
            command_decoder <= fdp_pkg::FDP_CMD_IDLE;
            rdMode <= fdp_pkg::FDP_RD_ARRAY;
            read_configuration_register <= fdp_pkg::RCR_RESET;
            statusReg <= 7'h0;
            lockBits <= '0;
        end
        else
        begin
            command_decoder <= next_command_decoder;
            rdMode <= next_rdMode;
            read_configuration_register <= next_read_configuration_register;
            statusReg <= next_statusReg;
            lockBits <= next_lockBits;
        end

    // Array and protection storage
    always_ff @(posedge core_clk)
    begin
        if (doProgram)
            memArray[wrIdx] <= latchedData;
        if (doProt)
            protection_and_lock_registers[latchedAddr[PROT_AW-1:0]] <= latchedData;
    end

    // ----------------------------------------
    // Link domain burst counter
    // ----------------------------------------
    logic              linkClk;
    logic [1:0]        lnkRstSync;
    logic [1:0]        lnkMeta;
    logic [1:0]        lnkSync;
    logic [BEAT_W-1:0] beatCnt;
    logic [BEAT_W-1:0] beatSynced;

    // Active edge chosen by parameter
    assign linkClk = busClk ^ CLK_FALL;

    // Link reset release and pin stages
    always_ff @(posedge linkClk or negedge arst_n)
        if (!arst_n)
        begin
            lnkRstSync <= 2'h0;
            lnkMeta <= 2'h3;
            lnkSync <= 2'h3;
        end
        else
        begin
            lnkRstSync <= {lnkRstSync[0], 1'b1};
            lnkMeta <= {selectN, address_valid_n};
            lnkSync <= lnkMeta;
        end

    always_ff @(posedge linkClk or negedge lnkRstSync[1])
        if (!lnkRstSync[1])
            beatCnt <= '0;
        else if (lnkSync[1] || !lnkSync[0])
            beatCnt <= '0;
        else
            beatCnt <= beatCnt + 1'b1;

    // Beat count into the core domain
    fdp_gray_sync #(
        .W(BEAT_W)
    ) beatXing (
        .srcClk (linkClk),
        .srcRstN(lnkRstSync[1]),
        .srcBin (beatCnt),
        .dstClk (core_clk),
        .dstRstN(coreRstN),
        .dstBin (beatSynced)
    );

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    logic              syncMode;
    logic              waitPol;
    logic [ADDR_W-1:0] startAddr;
    logic [BEAT_W-1:0] servedBeat;
    logic              burstReady;
    logic [MEM_AW-1:0] rdIdx;
    logic [7:0]        identOff;
    logic [15:0]       identWord;
    logic [15:0]       dataWord;
    logic              waitActive;
    logic              driveData;

    assign syncMode = !read_configuration_register[fdp_pkg::RCR_ASYNC_BIT];
    assign waitPol = read_configuration_register[fdp_pkg::RCR_WAIT_POL_BIT];
    assign rdIdx = syncMode ? startAddr[MEM_AW-1:0] + beatSynced[MEM_AW-1:0] :
                              addrSync[MEM_AW-1:0];
    assign identOff = addrSync[7:0];
    assign identWord = identOff == fdp_pkg::IDENT_MAKER  ? fdp_pkg::MAKER_CODE :
                       identOff == fdp_pkg::IDENT_DEVICE ? fdp_pkg::DEVICE_CODE :
                       identOff == fdp_pkg::IDENT_LOCK   ? {15'h0, lockBits[addrSync[MEM_AW-1 -: BLK_AW]]} :
                       identOff == fdp_pkg::IDENT_RCR    ? read_configuration_register :
                       identOff >= fdp_pkg::IDENT_PROT_BASE ?
                           protection_and_lock_registers[identOff[PROT_AW-1:0]] : 16'h0;
    assign dataWord = rdMode == fdp_pkg::FDP_RD_STATUS ? {8'h0, 1'b1, statusReg} :
                      rdMode == fdp_pkg::FDP_RD_IDENT  ? identWord : memArray[rdIdx];
    assign burstReady = !advAct && servedBeat == beatSynced;
    // wait held for non-array, async and writes
    assign waitActive = weAct || command_decoder != fdp_pkg::FDP_CMD_IDLE ||
                        (oeAct && (!syncMode || rdMode != fdp_pkg::FDP_RD_ARRAY || !burstReady));
    assign driveData = selAct && oeAct && !weAct && !pinRst;

    always_ff @(posedge core_clk or negedge coreRstN)
        if (!coreRstN)
        begin
            startAddr <= '0;
            servedBeat <= '0;
        end
        else
        begin
            if (advAct)
                startAddr <= addrSync;
            servedBeat <= beatSynced;
        end

    always_ff @(posedge core_clk or negedge coreRstN)
        if (!coreRstN)
        begin
            dataOut <= 16'h0;
            dataOe  <= 1'b0;
            waitOut <= 1'b0;
            waitOe  <= 1'b0;
            standby <= 1'b1;
        end
        else
        begin
            dataOut <= dataWord;
            dataOe  <= driveData;
            waitOut <= waitActive ? waitPol : !waitPol;
            waitOe  <= selAct;
            standby <= !selAct;
        end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!coreRstN);

    sequence advPulse;
        advAct ##1 !advAct;
    endsequence

    sequence resetPulse;
        pinRst ##1 !pinRst;
    endsequence

    data_float_a: assert property ((!selAct || !oeAct) |=> !dataOe)
        else $error("data bus driven while deselected");
    sel_active_a: assert property (selAct |=> !standby)
        else $error("selected die left in standby");
    deselect_float_a: assert property (!selAct |=> !waitOe && standby)
        else $error("wait driven while deselected");
    reset_write_a: assert property (pinRst |=> !writePending)
        else $error("write accepted during reset");
    reset_mode_a: assert property (resetPulse |-> rdMode == fdp_pkg::FDP_RD_ARRAY
        && command_decoder == fdp_pkg::FDP_CMD_IDLE && !syncMode)
        else $error("reset did not return to async array read");
    read_drive_a: assert property (driveData |=> dataOe && dataOut == $past(dataWord))
        else $error("read data not driven");
    status_cmd_a: assert property (writePending && !pinRst
        && command_decoder == fdp_pkg::FDP_CMD_IDLE && cmdByte == fdp_pkg::CMD_READ_STATUS
        |=> rdMode == fdp_pkg::FDP_RD_STATUS)
        else $error("status command not decoded");
    write_capture_a: assert property (writeStrobe |=> writePending
        && latchedData == $past(dataSync) && latchedAddr == $past(addrSync))
        else $error("write not captured at enable rise");
    addr_latch_a: assert property (advPulse |-> startAddr == $past(addrSync))
        else $error("burst start address not latched");
    status_read_a: assert property (rdMode == fdp_pkg::FDP_RD_STATUS
        |=> dataOut[fdp_pkg::STATUS_READY_BIT])
        else $error("status read lost ready bit");
    wait_level_a: assert property (selAct ##1 waitOe |-> waitOut ==
        ($past(waitActive) ? $past(waitPol) : !$past(waitPol)))
        else $error("wait level not set by polarity bit");
    burst_wait_a: assert property (syncMode && oeAct && !burstReady && selAct
        |=> waitOut == $past(waitPol))
        else $error("wait clear while burst data invalid");
    write_wait_a: assert property (weAct ##1 weAct |-> waitOut == $past(waitPol))
        else $error("wait not asserted during write");
    beat_count_a: assert property (@(posedge linkClk) disable iff (!lnkRstSync[1])
        !lnkSync[1] && lnkSync[0] |=> beatCnt == $past(beatCnt) + 1'b1)
        else $error("burst counter did not advance");
endmodule

/* tb/fdp_host_model.sv */
module fdp_host_model (
    input  wire logic                       core_clk,
    input  wire logic [15:0]                dataOut,
    input  wire logic                       dataOe,
    output logic      [fdp_pkg::ADDR_W-1:0] addrIn,
    output logic      [15:0]                dataIn,
    output logic                            selectN,
    output logic                            outEnableN,
    output logic                            writeEnableN,
    output logic                            address_valid_n,
    output logic                            resetPinN,
    output logic                            busClk
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        hostDrv;
    logic [15:0] hostData;
    logic [15:0] lastWire;

    // Released wire shows the inverse of its last value
    assign dataIn = dataOe ? dataOut : (hostDrv ? hostData : ~lastWire);
    always @(posedge core_clk) lastWire <= dataIn;

    // Idle pins at time zero
    initial
    begin
        {addrIn, hostData, lastWire, hostDrv, busClk} = '0;
        {selectN, outEnableN, writeEnableN, address_valid_n, resetPinN} = 5'h1f;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [22:0] a, input logic [15:0] d);
        outEnableN = 1'b1;
        addrIn = a;
        hostData = d;
        hostDrv = 1'b1;
        selectN = 1'b0;
        writeEnableN = 1'b0;
        cyc(4);
        writeEnableN = 1'b1;
        cyc(4);
        hostDrv = 1'b0;
        cyc(3);
    endtask

    task automatic rdStart(input logic [22:0] a);
        hostDrv = 1'b0;
        addrIn = a;
        selectN = 1'b0;
        outEnableN = 1'b0;
    endtask

    // Start a burst: address valid low, then high
    task automatic valid(input logic [22:0] a);
        rdStart(a);
        address_valid_n = 1'b0;
        cyc(4);
        address_valid_n = 1'b1;
    endtask

    task automatic idle();
        {outEnableN, selectN, address_valid_n} = 3'h7;
    endtask

    task automatic pinReset(input logic v);
        resetPinN = v;
        cyc(4);
    endtask

    // One link clock period, still otherwise
    task automatic clkPulse();
        busClk = 1'b1;
        #3;
        busClk = 1'b0;
        #3;
    endtask
endmodule

/* tb/flash_die_bus_port_tb_top.sv */
module flash_die_bus_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                       core_clk;
    logic                       arst_n;
    logic [fdp_pkg::ADDR_W-1:0] addrIn;
    logic [15:0]                dataIn;
    logic [15:0]                dataOut;
    logic                       dataOe;
    logic                       selectN;
    logic                       outEnableN;
    logic                       writeEnableN;
    logic                       address_valid_n;
    logic                       resetPinN;
    logic                       busClk;
    logic                       waitOut;
    logic                       waitOe;
    logic                       standby;
    int                         nErrors = 0;
    int                         compares = 0;

    fdp_bus_port u_fdp_bus_port (
        .core_clk(core_clk), .arst_n(arst_n), .busClk(busClk), .addrIn(addrIn),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .selectN(selectN),
        .outEnableN(outEnableN), .writeEnableN(writeEnableN),
        .address_valid_n(address_valid_n), .resetPinN(resetPinN), .waitOut(waitOut),
        .waitOe(waitOe), .standby(standby)
    );

    fdp_host_model u_fdp_host_model (
        .core_clk(core_clk), .dataOut(dataOut), .dataOe(dataOe), .addrIn(addrIn),
        .dataIn(dataIn), .selectN(selectN), .outEnableN(outEnableN),
        .writeEnableN(writeEnableN), .address_valid_n(address_valid_n),
        .resetPinN(resetPinN), .busClk(busClk)
    );

    // Core clock, 20 ns
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            nErrors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic giveVerdict();
        if (nErrors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Deselected die floats data and wait
    task automatic testIdle();
        u_fdp_host_model.cyc(3);
        chk(16'(dataOe), 16'h0);
        chk(16'(waitOe), 16'h0);
        chk(16'(standby), 16'h1);
    endtask

    // Program two words, read the first back asynchronously
    task automatic testProgram();
        u_fdp_host_model.wr(23'h5, 16'h0040);
        u_fdp_host_model.wr(23'h5, 16'h1234);
        u_fdp_host_model.wr(23'h6, 16'h0040);
        u_fdp_host_model.wr(23'h6, 16'h5678);
        u_fdp_host_model.wr(23'h0, 16'h00ff);
        u_fdp_host_model.rdStart(23'h5);
        u_fdp_host_model.cyc(4);
        chk(16'(dataOe), 16'h1);
        chk(dataOut, 16'h1234);
        chk(16'(standby), 16'h0);
        chk(16'(waitOe), 16'h1);
        chk(16'(waitOut), 16'h0);
        u_fdp_host_model.idle();
        u_fdp_host_model.cyc(4);
        chk(16'(dataOe), 16'h0);
    endtask

    // Status read returns ready bit
    task automatic testStatus();
        u_fdp_host_model.wr(23'h0, 16'h0070);
        u_fdp_host_model.rdStart(23'h0);
        u_fdp_host_model.cyc(4);
        chk(dataOut, 16'h0080);
        u_fdp_host_model.idle();
    endtask

    // Writes blocked in reset; array mode after
    task automatic testResetPin();
        u_fdp_host_model.pinReset(1'b0);
        u_fdp_host_model.wr(23'h5, 16'h0040);
        u_fdp_host_model.wr(23'h5, 16'hbeef);
        u_fdp_host_model.pinReset(1'b1);
        u_fdp_host_model.rdStart(23'h5);
        u_fdp_host_model.cyc(4);
        chk(dataOut, 16'h1234);
        u_fdp_host_model.idle();
    endtask

    // Sync burst, wait active high
    task automatic testBurst();
        // Link edges while deselected release the link reset
        repeat (3) u_fdp_host_model.clkPulse();
        u_fdp_host_model.cyc(1);
        u_fdp_host_model.wr(23'h400, 16'h0060);
        u_fdp_host_model.wr(23'h400, 16'h0003);
        u_fdp_host_model.valid(23'h5);
        u_fdp_host_model.cyc(6);
        chk(16'(waitOut), 16'h0);
        chk(dataOut, 16'h1234);
        // Two sync edges, one count edge, one gray edge
        repeat (4) u_fdp_host_model.clkPulse();
        u_fdp_host_model.cyc(6);
        chk(16'(waitOut), 16'h0);
        chk(dataOut, 16'h5678);
        chk(16'(waitOe), 16'h1);
        u_fdp_host_model.idle();
    endtask

    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        u_fdp_host_model.cyc(5);
        testIdle();
        testProgram();
        testStatus();
        testResetPin();
        testBurst();
        giveVerdict();
    end

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge core_clk);
        nErrors++;
        giveVerdict();
    end
endmodule
